// ==== verilog/tcc_pkg.sv ====
// constants, register map and carrier types for the timers with capture/compare
// Contract
// RULE_01: first timer counts up over 16 bits, wraps, sets overflow flag.
// RULE_02: first timer prescale code 00..11 divides input by 1, 2, 4, 8.
// RULE_03: clock-source bit zero makes first timer count the instruction clock.
// RULE_04: reading either first timer byte returns a coherent value.
// RULE_05: software stops first timer before writing its count bytes.
// RULE_06: oscillator-enable bit starts the crystal oscillator, kept running in sleep.
// RULE_07: special-event mode compare match clears the first timer count.
// RULE_08: special-event clear never sets the first timer overflow flag.
// RULE_09: a software write beats a special-event clear in the same cycle.
// RULE_10: software uses internal or synchronised counting with special-event clear.
// RULE_11: first timer count bytes survive every reset.
// RULE_12: first timer control clears on power-on or brown-out reset only.
// RULE_13: any write to a first timer byte clears its prescaler.
// RULE_14: second timer prescale: 00 by one, 01 by four, 1x by sixteen.
// RULE_15: second timer counts to its period, then returns to zero with a match.
// RULE_16: any reset clears second timer count and loads period with all ones.
// RULE_17: match pulses pass 4-bit postscaler; terminal count sets second timer flag.
// RULE_18: second timer counts only while its on bit is one.
// RULE_19: count or control writes and resets clear second timer pre/postscalers.
// RULE_20: second timer match pulse before postscaler is an output.
// RULE_21: mode 0000 turns the unit off and resets it; 11xx selects PWM (decoded as is_pwm here, but it drives no PWM output).
// RULE_22: capture modes 0100 fall, 0101 rise, 0110 4th rise, 0111 16th rise.
// RULE_23: compare 1000 drives high, 1001 low, 1010 flag only.
// RULE_24: capture copies full 16-bit count and sets the event flag.
// RULE_25: a new capture overwrites an unread captured value.
// RULE_26: software keeps the pin an input while capturing.
// RULE_27: external count and capture inputs are synchronised into edge pulses.
package tcc_pkg;
  // byte addresses (printed offsets are not word multiples: index * 4)
  localparam logic [7:0] IDX_INTCTL  = 8'h0b;
  localparam logic [7:0] IDX_FLAGS   = 8'h0c;
  localparam logic [7:0] IDX_T1LO    = 8'h0e;
  localparam logic [7:0] IDX_T1HI    = 8'h0f;
  localparam logic [7:0] IDX_T1CTL   = 8'h10;
  localparam logic [7:0] IDX_T2CNT   = 8'h11;
  localparam logic [7:0] IDX_T2CTL   = 8'h12;
  localparam logic [7:0] IDX_CCPLO   = 8'h15;
  localparam logic [7:0] IDX_CCPHI   = 8'h16;
  localparam logic [7:0] IDX_CCPCTL  = 8'h17;
  localparam logic [7:0] IDX_ENABLES = 8'h8c;
  localparam logic [7:0] IDX_T2PER   = 8'h92;
  localparam logic [7:0] IDX_RSTCTL  = 8'ha0;
  // reset values
  localparam logic [7:0] T1CTL_RST = 8'h00;
  localparam logic [7:0] T2PER_RST = 8'hff;
  // field positions
  localparam int T1_ON = 0;
  localparam int T1_CS = 1;
  localparam int T1_NOSYNC = 2;
  localparam int T1_OSCEN = 3;
  localparam int T2_ON = 2;
  localparam int FL_T1 = 0;
  localparam int FL_T2 = 1;
  localparam int FL_CCP = 2;
  // ccp mode codes
  localparam logic [3:0] M_OFF  = 4'h0;
  localparam logic [3:0] M_CFAL = 4'h4;
  localparam logic [3:0] M_CRIS = 4'h5;
  localparam logic [3:0] M_C4   = 4'h6;
  localparam logic [3:0] M_C16  = 4'h7;
  localparam logic [3:0] M_SET  = 4'h8;
  localparam logic [3:0] M_CLR  = 4'h9;
  localparam logic [3:0] M_SW   = 4'ha;
  localparam logic [3:0] M_SPEC = 4'hb;
  localparam int CLK_MHZ = 100;
  localparam int INSTR_DIV = 4;
  localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);
  typedef struct packed {
    logic       cyc;
    logic       stb;
    logic       we;
    logic [9:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } tcc_wb_req_s;
  typedef struct packed {
    logic       ack;
    logic [31:0] dat;
  } tcc_wb_rsp_s;
endpackage : tcc_pkg

// ==== verilog/tcc_top.sv ====
// two timers with capture/compare unit behind a wishbone slave
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
module tcc_top (
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic             por_n,
  input  wire tcc_pkg::tcc_wb_req_s wb_req,
  output tcc_pkg::tcc_wb_rsp_s  wb_rsp,
  input  wire logic             t1_ext_clk,
  input  wire logic             ccp_pin_in,
  output logic                  ccp_pin_out,
  output logic                  ccp_pin_oe,
  output logic                  crystal_osc_enable,
  output logic                  t2_match_pulse,
  output logic                  irq_out
);
  import tcc_pkg::*;

  logic [7:0] t1_count_reg, intc_reg, flags_reg, en_reg, t1ctl_reg;
  logic [7:0] t2cnt_reg, t2ctl_reg, t2per_reg, ccpctl_reg;
  logic [15:0] ccp_value_reg;
  logic [7:0] t1hi_reg;
  logic [2:0] t1pre_reg;
  logic [3:0] t2pre_reg, t2post_reg, ccppre_reg;
  logic [1:0] instr_div_reg;
  logic [2:0] ext_sync_reg, pin_sync_reg;
  logic       ack_reg, cmp_out_reg, match_seen_reg;
  logic [31:0] rd_reg;

  // bus decode
  wire       bus_req = wb_req.cyc & wb_req.stb & ~ack_reg;
  wire [7:0] idx     = wb_req.adr[9:2];
  // writes land at the edge where the master samples ack high
  wire       wr      = wb_req.cyc & wb_req.stb & ack_reg & wb_req.we
                       & wb_req.sel[0];
  wire [7:0] wd      = wb_req.dat[7:0];
  wire wr_t1lo = wr & (idx == IDX_T1LO);
  wire wr_t1hi = wr & (idx == IDX_T1HI);
  wire wr_t1   = wr_t1lo | wr_t1hi;
  wire wr_t2c  = wr & (idx == IDX_T2CNT);
  wire wr_t2k  = wr & (idx == IDX_T2CTL);
  wire wr_ccpl = wr & (idx == IDX_CCPLO);
  wire wr_ccph = wr & (idx == IDX_CCPHI);
  wire wr_ccpk = wr & (idx == IDX_CCPCTL);
  wire wr_flag = wr & (idx == IDX_FLAGS);

  // instruction-clock enable, oscillator / 4
  wire instr_en = (instr_div_reg == INSTR_LAST); // RULE_03

  // pin edges after three stages; stages two and three compared
  wire ext_rise = ext_sync_reg[1] & ~ext_sync_reg[2];  // RULE_27
  wire pin_rise = pin_sync_reg[1] & ~pin_sync_reg[2];  // RULE_27
  wire pin_fall = ~pin_sync_reg[1] & pin_sync_reg[2];  // RULE_27

  // first timer input select and prescale
  wire t1_src = t1ctl_reg[T1_CS] ? ext_rise : instr_en;       // RULE_03
  wire t1_tick_in = t1ctl_reg[T1_ON] & t1_src;
  wire [1:0] t1ps = t1ctl_reg[5:4];
  wire t1_pre_done = (t1pre_reg == 3'((1 << t1ps) - 1));      // RULE_02
  wire t1_inc = t1_tick_in & t1_pre_done;
  wire t1_wrap = t1_inc & (t1_count_reg == 8'hff) & (t1hi_reg == 8'hff);
  wire [15:0] t1_full = {t1hi_reg, t1_count_reg};

  // ccp mode decode
  wire [3:0] mode = ccpctl_reg[3:0];
  wire is_capture = (mode[3:2] == 2'b01);                      // RULE_22
  wire is_compare = (mode[3:2] == 2'b10);                      // RULE_23
  wire is_pwm     = (mode[3:2] == 2'b11);                      // RULE_21
  wire [3:0] cap_div = (mode == M_C16) ? 4'hf :
                       (mode == M_C4) ? 4'h3 : 4'h0;
  wire cap_edge = (mode == M_CFAL) ? pin_fall : pin_rise;      // RULE_22
  wire cap_evt = is_capture & cap_edge & (ccppre_reg == cap_div);
  wire cmp_hit = is_compare & (t1_full == ccp_value_reg);
  wire cmp_evt = cmp_hit & ~match_seen_reg;
  wire spec_rst = cmp_evt & (mode == M_SPEC);                  // RULE_07

  // second timer
  wire [3:0] t2_div = t2ctl_reg[1] ? 4'hf :
                      t2ctl_reg[0] ? 4'h3 : 4'h0;              // RULE_14
  wire t2_tick = t2ctl_reg[T2_ON] & instr_en;                  // RULE_18
  wire t2_inc = t2_tick & (t2pre_reg == t2_div);
  wire t2_match = t2_inc & (t2cnt_reg == t2per_reg);           // RULE_15
  wire t2_post_done = t2_match & (t2post_reg == t2ctl_reg[6:3]); // RULE_17

  // read mux; both bytes are in sys_clk domain so reads are coherent
  logic [7:0] rd_byte;
  always_comb begin
    case (idx)
      IDX_INTCTL:  rd_byte = intc_reg;
      IDX_FLAGS:   rd_byte = {5'h00, flags_reg[2:0]};
      IDX_T1LO:    rd_byte = t1_count_reg;                     // RULE_04
      IDX_T1HI:    rd_byte = t1hi_reg;                         // RULE_04
      IDX_T1CTL:   rd_byte = {2'b00, t1ctl_reg[5:0]};
      IDX_T2CNT:   rd_byte = t2cnt_reg;
      IDX_T2CTL:   rd_byte = {1'b0, t2ctl_reg[6:0]};
      IDX_CCPLO:   rd_byte = ccp_value_reg[7:0];
      IDX_CCPHI:   rd_byte = ccp_value_reg[15:8];
      IDX_CCPCTL:  rd_byte = {2'b00, ccpctl_reg[5:0]};
      IDX_ENABLES: rd_byte = {5'h00, en_reg[2:0]};
      IDX_T2PER:   rd_byte = t2per_reg;
      default:     rd_byte = 8'h00;
    endcase
  end

  // bus answer one cycle after request
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ack_reg <= 1'b0;
      rd_reg  <= 32'h0;
    end else begin
      ack_reg <= bus_req;
      rd_reg  <= {24'h0, rd_byte};
    end
  end

  // synchronisers and instruction divider
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ext_sync_reg  <= 3'h0;
      pin_sync_reg  <= 3'h0;
      instr_div_reg <= 2'h0;
    end else begin
      ext_sync_reg  <= {ext_sync_reg[1:0], t1_ext_clk};
      pin_sync_reg  <= {pin_sync_reg[1:0], ccp_pin_in};
      instr_div_reg <= instr_div_reg + 2'h1;
    end
  end

  // first timer control: only power-on/brown-out clears it
  always_ff @(posedge sys_clk) begin
    if (!por_n) t1ctl_reg <= T1CTL_RST;                        // RULE_12
    else if (wr & (idx == IDX_T1CTL)) t1ctl_reg <= {2'b00, wd[5:0]};
  end

  // first timer count: no reset at all
  always_ff @(posedge sys_clk) begin
    if (wr_t1lo) t1_count_reg <= wd;                           // RULE_09
    else if (spec_rst) t1_count_reg <= 8'h00;                  // RULE_07
    else if (t1_inc) t1_count_reg <= t1_count_reg + 8'h01;     // RULE_01
    if (wr_t1hi) t1hi_reg <= wd;                               // RULE_09
    else if (spec_rst & ~wr_t1lo) t1hi_reg <= 8'h00;           // RULE_07
    else if (t1_inc & (t1_count_reg == 8'hff))
      t1hi_reg <= t1hi_reg + 8'h01;
  end

  // first timer prescaler
  always_ff @(posedge sys_clk) begin
    if (!rstn | wr_t1) t1pre_reg <= 3'h0;                      // RULE_13
    else if (t1_tick_in) t1pre_reg <= t1_pre_done ? 3'h0 : t1pre_reg + 3'h1;
  end

  // second timer count, period, scalers
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      t2cnt_reg  <= 8'h00;                                     // RULE_16
      t2per_reg  <= T2PER_RST;                                 // RULE_16
      t2ctl_reg  <= 8'h00;
      t2pre_reg  <= 4'h0;
      t2post_reg <= 4'h0;
    end else begin
      if (wr & (idx == IDX_T2PER)) t2per_reg <= wd;
      if (wr_t2k) t2ctl_reg <= {1'b0, wd[6:0]};
      if (wr_t2c) t2cnt_reg <= wd;
      else if (t2_inc & ~wr_t2k)                               // RULE_19
        t2cnt_reg <= t2_match ? 8'h00 : t2cnt_reg + 8'h01;
      if (wr_t2c | wr_t2k) begin
        t2pre_reg  <= 4'h0;                                    // RULE_19
        t2post_reg <= 4'h0;                                    // RULE_19
      end else begin
        if (t2_tick) t2pre_reg <= (t2pre_reg == t2_div) ? 4'h0
                                                        : t2pre_reg + 4'h1;
        if (t2_match) t2post_reg <= t2_post_done ? 4'h0 : t2post_reg + 4'h1;
      end
    end
  end

  // ccp control, capture prescaler, compare latch
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ccpctl_reg     <= 8'h00;
      ccppre_reg     <= 4'h0;
      cmp_out_reg    <= 1'b0;
      match_seen_reg <= 1'b0;
    end else begin
      if (wr_ccpk) ccpctl_reg <= {2'b00, wd[5:0]};
      match_seen_reg <= cmp_hit;
      if (!is_capture | (mode == M_OFF)) ccppre_reg <= 4'h0;   // RULE_21
      else if (cap_edge)
        ccppre_reg <= (ccppre_reg == cap_div) ? 4'h0 : ccppre_reg + 4'h1;
      if (mode == M_OFF) cmp_out_reg <= 1'b0;                  // RULE_21
      else if (cmp_evt & (mode == M_SET)) cmp_out_reg <= 1'b1; // RULE_23
      else if (cmp_evt & (mode == M_CLR)) cmp_out_reg <= 1'b0; // RULE_23
    end
  end

  // ccp value: capture overwrites any unread value
  always_ff @(posedge sys_clk) begin
    if (cap_evt) ccp_value_reg <= t1_full;                     // RULE_25
    else begin
      if (wr_ccpl) ccp_value_reg[7:0] <= wd;
      if (wr_ccph) ccp_value_reg[15:8] <= wd;
    end
  end

  // flags: hardware set wins over software clear
  wire [2:0] flag_set = {cap_evt | cmp_evt,                    // RULE_24
                         t2_post_done,                         // RULE_17
                         t1_wrap & ~spec_rst};                 // RULE_08
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      flags_reg <= 8'h00;
      en_reg    <= 8'h00;
      intc_reg  <= 8'h00;
    end else begin
      flags_reg <= {5'h00, (wr_flag ? wd[2:0] : flags_reg[2:0]) | flag_set};
      if (wr & (idx == IDX_ENABLES)) en_reg <= {5'h00, wd[2:0]};
      if (wr & (idx == IDX_INTCTL)) intc_reg <= wd;
    end
  end

  // outputs
  assign wb_rsp.ack = ack_reg;
  assign wb_rsp.dat = rd_reg;
  assign ccp_pin_out = cmp_out_reg;
  assign ccp_pin_oe  = is_compare & (mode != M_SW) & (mode != M_SPEC);
  assign crystal_osc_enable = t1ctl_reg[T1_OSCEN];             // RULE_06
  assign t2_match_pulse = t2_match;                            // RULE_20
  assign irq_out = intc_reg[7] & intc_reg[6] & |(flags_reg[2:0] & en_reg[2:0]);

  // checks
  a_spec_no_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
    spec_rst |=> !flags_reg[FL_T1] || $past(flags_reg[FL_T1]))
    else $error("special clear set overflow flag"); // RULE_08
  a_write_beats_spec: assert property (@(posedge sys_clk) disable iff (!rstn)
    (spec_rst && wr_t1lo) |=> t1_count_reg == $past(wd))
    else $error("write lost to special clear"); // RULE_09
  a_capture_copy: assert property (@(posedge sys_clk) disable iff (!rstn)
    cap_evt |=> ccp_value_reg == $past(t1_full) && flags_reg[FL_CCP])
    else $error("capture did not copy count"); // RULE_24
  a_t2_wrap: assert property (@(posedge sys_clk) disable iff (!rstn)
    t2_match && !wr_t2c |=> t2cnt_reg == 8'h00)
    else $error("second timer did not wrap"); // RULE_15
  a_t2_off_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
    !t2ctl_reg[T2_ON] && !wr_t2c |=> $stable(t2cnt_reg))
    else $error("second timer moved while off"); // RULE_18
  a_t2_ctl_clr: assert property (@(posedge sys_clk) disable iff (!rstn)
    wr_t2k |=> t2pre_reg == 4'h0 && t2post_reg == 4'h0 && $stable(t2cnt_reg))
    else $error("control write mishandled scalers"); // RULE_19
  a_t1_pre_clr: assert property (@(posedge sys_clk) disable iff (!rstn)
    wr_t1 |=> t1pre_reg == 3'h0)
    else $error("prescaler not cleared on count write"); // RULE_13
  a_cmp_high: assert property (@(posedge sys_clk) disable iff (!rstn)
    cmp_evt && mode == M_SET && !wr_ccpk |=> ccp_pin_out)
    else $error("compare set failed"); // RULE_23
  a_ccp_off: assert property (@(posedge sys_clk) disable iff (!rstn)
    mode == M_OFF |=> !ccp_pin_out && ccppre_reg == 4'h0)
    else $error("ccp off did not reset"); // RULE_21
  a_t1_wrap_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
    t1_wrap && !spec_rst && !wr_t1 |=> t1_full == 16'h0 && flags_reg[FL_T1])
    else $error("first timer wrap wrong"); // RULE_01
endmodule : tcc_top
`default_nettype wire

// ==== tb/tcc_pin_model.sv ====
// far-side pin model: capture pin and external count clock
`timescale 1ns/100ps
`default_nettype none
module tcc_pin_model (
  input  wire logic sys_clk,
  output var logic  ccp_pin_in,
  output var logic  t1_ext_clk
);
  // both pins are plain driven inputs of the device, idle low
  initial begin
    ccp_pin_in = 1'b0;
    t1_ext_clk = 1'b0;
  end
  // full pulses on the capture pin, never driven from the device side
  task automatic pulse_ccp(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (8) @(posedge sys_clk);
      ccp_pin_in <= 1'b1;
      repeat (8) @(posedge sys_clk);
      ccp_pin_in <= 1'b0;
    end
    // let the last edge pass the synchroniser before returning
    repeat (8) @(posedge sys_clk);
  endtask : pulse_ccp
  // slow count clock, wide enough for any synchroniser
  task automatic pulse_ext(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (8) @(posedge sys_clk);
      t1_ext_clk <= 1'b1;
      repeat (8) @(posedge sys_clk);
      t1_ext_clk <= 1'b0;
    end
  endtask : pulse_ext
endmodule : tcc_pin_model
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the timers with capture/compare
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import tcc_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        por_n = 1'b0;
  tcc_wb_req_s wb_req = '0;
  tcc_wb_rsp_s wb_rsp;
  logic        ccp_in, ext_clk, pin_out, pin_oe, osc_en, match, irq;
  int          num_errors = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          n;
  logic [7:0]  rd;
  logic [15:0] v;
  // register rows: index, write data, readback
  logic [23:0] wr_rows[8] = '{{IDX_T1CTL, 8'hc8, 8'h08},
    {IDX_T2CTL, 8'h80, 8'h00}, {IDX_CCPCTL, 8'hc0, 8'h00},
    {IDX_T2PER, 8'h5a, 8'h5a}, {IDX_ENABLES, 8'h07, 8'h07},
    {IDX_INTCTL, 8'hc0, 8'hc0}, {IDX_T2CNT, 8'h42, 8'h42},
    {8'h33, 8'h5a, 8'h00}};
  logic [15:0] rst_rows[6] = '{{IDX_T1CTL, 8'h00}, {IDX_T2CNT, 8'h00},
    {IDX_T2CTL, 8'h00}, {IDX_T2PER, 8'hff}, {IDX_FLAGS, 8'h00},
    {IDX_ENABLES, 8'h00}};
  logic [3:0]  cmp_mode[3] = '{M_SET, M_SW, M_CLR};
  logic [1:0]  cmp_exp[3] = '{2'b11, 2'b10, 2'b01};

  always #5 sys_clk = ~sys_clk;

  tcc_pin_model pm (.sys_clk(sys_clk), .ccp_pin_in(ccp_in),
                    .t1_ext_clk(ext_clk));
  tcc_top uut (.sys_clk(sys_clk), .rstn(rstn), .por_n(por_n),
    .wb_req(wb_req), .wb_rsp(wb_rsp), .t1_ext_clk(ext_clk),
    .ccp_pin_in(ccp_in), .ccp_pin_out(pin_out), .ccp_pin_oe(pin_oe),
    .crystal_osc_enable(osc_en), .t2_match_pulse(match), .irq_out(irq));

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop
  // hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one classic wishbone cycle, held until ack is sampled
  task automatic bus(input logic [7:0] idx, input logic we,
                     input logic [7:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    wb_req <= '{1'b1, 1'b1, we, {idx, 2'b00}, 4'h1, {24'h0, d}};
    do begin
      @(posedge sys_clk);
      k++;
    end while (wb_rsp.ack !== 1'b1 && k < 20);
    rd = wb_rsp.dat[7:0];
    if (k >= 20) begin
      num_errors++;
      report_and_stop();
    end
    wb_req <= '0;
    @(posedge sys_clk);
  endtask : bus
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(idx, 1'b1, d);
  endtask : wr
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    bus(idx, 1'b0, 8'h00);
    chk({8'h00, rd}, {8'h00, exp});
  endtask : rdc
  task automatic set16(input logic [7:0] lo, input logic [15:0] val);
    wr(lo, val[7:0]);
    wr(lo + 8'h01, val[15:8]);
  endtask : set16
  task automatic get16(input logic [7:0] lo);
    bus(lo, 1'b0, 8'h00);
    v[7:0] = rd;
    bus(lo + 8'h01, 1'b0, 8'h00);
    v[15:8] = rd;
  endtask : get16
  task automatic chk_rst(input logic [7:0] t1c);
    for (int i = 0; i < 6; i++)
      rdc(rst_rows[i][15:8], i == 0 ? t1c : rst_rows[i][7:0]);
  endtask : chk_rst
  // edges until the next timer2 match, bounded
  task automatic wait_match(output int k);
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (match !== 1'b1 && k < 2000);
  endtask : wait_match

  initial begin
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    por_n <= 1'b1;
    chk_rst(8'h00);
    // ordinary register cases
    for (int i = 0; i < 8; i++) begin
      wr(wr_rows[i][23:16], wr_rows[i][15:8]);
      rdc(wr_rows[i][23:16], wr_rows[i][7:0]);
    end
    chk({15'h0, osc_en}, 16'h1);
    // plain reset keeps timer1, power-on reset clears its control
    set16(IDX_T1LO, 16'h1234);
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    get16(IDX_T1LO);
    chk(v, 16'h1234);
    chk_rst(8'h08);
    rstn <= 1'b0;
    por_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    por_n <= 1'b1;
    rdc(IDX_T1CTL, 8'h00);
    // timer2 period and prescale: gap between matches
    wr(IDX_T2CNT, 8'h00);
    wr(IDX_T2PER, 8'h03);
    for (int i = 0; i < 4; i++) begin
      wr(IDX_T2CTL, {5'b00001, i[1:0]});
      wait_match(n);
      wait_match(n);
      chk(16'(n), 16'(16 << (i > 1 ? 4 : 2 * i)));
    end
    // postscale 1:2 sets the flag on the second match
    wr(IDX_T2CTL, 8'h00);
    wr(IDX_T2CNT, 8'h00);
    wr(IDX_FLAGS, 8'h00);
    wr(IDX_T2CTL, 8'h0c);
    wait_match(n);
    rdc(IDX_FLAGS, 8'h00);
    wait_match(n);
    rdc(IDX_FLAGS, 8'h02);
    wr(IDX_T2CTL, 8'h00);
    wr(IDX_T2CNT, 8'h37);
    wr(IDX_T2CTL, 8'h03);
    repeat (50) @(posedge sys_clk);
    rdc(IDX_T2CNT, 8'h37);
    // timer1 external count through each prescale code
    for (int i = 0; i < 4; i++) begin
      wr(IDX_T1CTL, 8'h00);
      set16(IDX_T1LO, 16'h00fe);
      wr(IDX_T1CTL, {2'b00, i[1:0], 4'b0011});
      pm.pulse_ext(16);
      get16(IDX_T1LO);
      chk(v, 16'h00fe + (16'h10 >> i));
    end
    // internal clock: overflow after 64 instruction cycles
    wr(IDX_T1CTL, 8'h00);
    set16(IDX_T1LO, 16'hffc0);
    wr(IDX_FLAGS, 8'h00);
    wr(IDX_T1CTL, 8'h01);
    repeat (200) @(posedge sys_clk);
    rdc(IDX_FLAGS, 8'h00);
    repeat (100) @(posedge sys_clk);
    rdc(IDX_FLAGS, 8'h01);
    rdc(IDX_T1HI, 8'h00);
    // special event makes the compare value the timer1 period
    wr(IDX_T1CTL, 8'h00);
    set16(IDX_CCPLO, 16'h0010);
    wr(IDX_CCPCTL, M_SPEC);
    set16(IDX_T1LO, 16'h0000);
    wr(IDX_FLAGS, 8'h00);
    wr(IDX_T1CTL, 8'h01);
    repeat (400) @(posedge sys_clk);
    get16(IDX_T1LO);
    chk(16'(v > 16'h0010), 16'h0);
    rdc(IDX_FLAGS, 8'h04);
    // compare pin actions
    for (int i = 0; i < 3; i++) begin
      wr(IDX_T1CTL, 8'h00);
      set16(IDX_T1LO, 16'h0000);
      wr(IDX_FLAGS, 8'h00);
      wr(IDX_CCPCTL, {4'h0, cmp_mode[i]});
      wr(IDX_T1CTL, 8'h01);
      repeat (200) @(posedge sys_clk);
      chk({14'h0, pin_out, pin_oe}, {14'h0, cmp_exp[i]});
      rdc(IDX_FLAGS, 8'h04);
    end
    wr(IDX_CCPCTL, M_OFF);
    @(posedge sys_clk);
    chk({15'h0, pin_out}, 16'h0);
    // capture modes with their edge counts
    wr(IDX_T1CTL, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(IDX_CCPCTL, M_OFF);
      set16(IDX_T1LO, {4'(i), 12'habc});
      wr(IDX_FLAGS, 8'h00);
      wr(IDX_CCPCTL, M_CFAL + 4'(i));
      pm.pulse_ccp(i < 2 ? 0 : (i == 2 ? 3 : 15));
      rdc(IDX_FLAGS, 8'h00);
      pm.pulse_ccp(1);
      rdc(IDX_FLAGS, 8'h04);
      get16(IDX_CCPLO);
      chk(v, {4'(i), 12'habc});
    end
    // second capture overwrites an unread value
    wr(IDX_CCPCTL, M_CRIS);
    set16(IDX_T1LO, 16'h1111);
    pm.pulse_ccp(1);
    set16(IDX_T1LO, 16'h2222);
    pm.pulse_ccp(1);
    get16(IDX_CCPLO);
    chk(v, 16'h2222);
    wr(IDX_INTCTL, 8'hc0);
    wr(IDX_ENABLES, 8'h04);
    chk({15'h0, irq}, 16'h1);
    wr(IDX_ENABLES, 8'h00);
    chk({15'h0, irq}, 16'h0);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
